/* src/solar_thermal_config_regs.sv */
`timescale 1ns/10ps
`default_nettype none
module solar_thermal_config_regs
    import solar_thermal_pkg::*;
#(
    parameter int TICK = TICK_CYCLES
) (
    input  wire logic              sys_clk,
    input  wire logic              srst,
    input  wire logic [7:0]        regAddr,
    input  wire logic [7:0]        regWrData,
    input  wire logic              regWrEn,
    input  wire logic              regRdEn,
    output logic [7:0]             regRdData,
    input  wire logic              regReset,
    input  wire logic              watchdogExpire,
    input  wire logic [VOLT_W-1:0] openCircuitVoltage,
    output logic                   converterHold,
    output logic [VOLT_W-1:0]      inputVoltageFloor,
    output logic                   floorUpdated,
    output logic [7:0]             thermalRegLimitC,
    output logic [7:0]             thermalTripLimitC,
    output logic                   inputRailPulldownOn,
    output logic                   firstSourcePulldownOn,
    output logic                   secondSourcePulldownOn,
    output logic                   warmChargeSuspend,
    output logic [9:0]             warmVoltageDropMv,
    output logic [PCT_W-1:0]       warmCurrentPct,
    output logic                   coolChargeSuspend,
    output logic [PCT_W-1:0]       coolCurrentPct
);
    // --------------------------------------------------------------
    // Helpers
    // --------------------------------------------------------------
    function automatic logic [VOLT_W-1:0] floorOf(
        input logic [VOLT_W-1:0] v,
        input logic [2:0]        code
    );
        logic [VOLT_W+4:0] prod;
        prod = (VOLT_W+5)'(v) * (VOLT_W+5)'(FRAC_BASE + {2'b00, code});
        return prod[FRAC_SHIFT +: VOLT_W];
    endfunction : floorOf

    function automatic logic [PCT_W-1:0] pctOf(input logic [1:0] code);
        return PCT_W'(CUR_PCT[code]);
    endfunction : pctOf

    function automatic logic [7:0] restore(
        input logic [7:0] cur,
        input logic [7:0] rst,
        input logic [7:0] mask
    );
        return (cur & ~mask) | (rst & mask);
    endfunction : restore

    logic [7:0]      trackReg_q;
    logic [7:0]      thermalReg_q;
    logic [7:0]      derateReg_q;
    logic            wrTrack;
    logic            wrThermal;
    logic            wrDerate;
    logic            allReset;
    logic [7:0]      readMux;
    logic [2:0]      fracCode;
    logic [1:0]      dlyCode;
    logic [1:0]      rateCode;
    logic            trackOn;
    track_state_type state_q;
    track_state_type state_d;

    tracking_timer_if tmr ();

    assign allReset  = srst || regReset;
    assign wrTrack   = regWrEn && (regAddr == TRACK_ADDR);
    assign wrThermal = regWrEn && (regAddr == THERMAL_ADDR);
    assign wrDerate  = regWrEn && (regAddr == DERATE_ADDR);
    assign fracCode  = trackReg_q[FRAC_LO +: 3];
    assign dlyCode   = trackReg_q[DLY_LO +: 2];
    assign rateCode  = trackReg_q[RATE_LO +: 2];
    assign trackOn   = trackReg_q[EN_BIT];

    // --------------------------------------------------------------
    // Register file
    // --------------------------------------------------------------
    // Watchdog leaves the tracking setup alone
    always_ff @(posedge sys_clk) begin
        if (allReset) begin
            trackReg_q <= TRACK_RST;
        end else if (wrTrack) begin
            trackReg_q <= regWrData & TRACK_WR_MASK;
        end
    end

    // Watchdog wins over a same-cycle write: defaults must land
    always_ff @(posedge sys_clk) begin
        if (allReset) begin
            thermalReg_q <= THERMAL_RST;
        end else if (watchdogExpire) begin
            thermalReg_q <= restore(thermalReg_q, THERMAL_RST,
                                    THERMAL_WD_MASK);
        end else if (wrThermal) begin
            thermalReg_q <= regWrData & THERMAL_WR_MASK;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (allReset) begin
            derateReg_q <= DERATE_RST;
        end else if (watchdogExpire) begin
            derateReg_q <= restore(derateReg_q, DERATE_RST,
                                   DERATE_WD_MASK);
        end else if (wrDerate) begin
            derateReg_q <= regWrData & DERATE_WR_MASK;
        end
    end

    always_comb begin
        unique case (regAddr)
            TRACK_ADDR:   readMux = trackReg_q;
            THERMAL_ADDR: readMux = thermalReg_q;
            DERATE_ADDR:  readMux = derateReg_q;
            default:      readMux = READ_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            regRdData <= READ_IDLE;
        end else if (regRdEn) begin
            regRdData <= readMux;
        end
    end

    // --------------------------------------------------------------
    // Decoded settings
    // --------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            thermalRegLimitC  <= '0;
            thermalTripLimitC <= '0;
        end else begin
            thermalRegLimitC  <=
                8'(REG_LIMIT_C[thermalReg_q[TREG_LO +: 2]]);
            thermalTripLimitC <=
                8'(TRIP_LIMIT_C[thermalReg_q[TRIP_LO +: 2]]);
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            inputRailPulldownOn    <= 1'b0;
            firstSourcePulldownOn  <= 1'b0;
            secondSourcePulldownOn <= 1'b0;
        end else begin
            inputRailPulldownOn    <= thermalReg_q[RAIL_BIT];
            firstSourcePulldownOn  <= thermalReg_q[SRC1_BIT];
            secondSourcePulldownOn <= thermalReg_q[SRC2_BIT];
        end
    end

    // Suspend code also carries a zero drop, so consumers need one flag
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            warmChargeSuspend <= 1'b0;
            warmVoltageDropMv <= '0;
            warmCurrentPct    <= '0;
            coolChargeSuspend <= 1'b0;
            coolCurrentPct    <= '0;
        end else begin
            warmChargeSuspend <= (derateReg_q[WVOLT_LO +: 3] == VOLT_SUSPEND)
                || (derateReg_q[WCUR_LO +: 2] == CUR_SUSPEND);
            warmVoltageDropMv <=
                10'(VOLT_DROP_MV[derateReg_q[WVOLT_LO +: 3]]);
            warmCurrentPct    <= pctOf(derateReg_q[WCUR_LO +: 2]);
            coolChargeSuspend <= derateReg_q[CCUR_LO +: 2] == CUR_SUSPEND;
            coolCurrentPct    <= pctOf(derateReg_q[CCUR_LO +: 2]);
        end
    end

    // --------------------------------------------------------------
    // Open-circuit tracking sequencer
    // --------------------------------------------------------------
    always_comb begin
        state_d    = state_q;
        tmr.start  = 1'b0;
        tmr.loadMs = MS_W'(SETTLE_MS[dlyCode]);
        unique case (state_q)
            ST_IDLE: begin
                if (trackOn) begin
                    state_d   = ST_SETTLE;
                    tmr.start = 1'b1;
                end
            end
            ST_WAIT: begin
                if (!trackOn) begin
                    state_d = ST_IDLE;
                end else if (tmr.expired) begin
                    state_d   = ST_SETTLE;
                    tmr.start = 1'b1;
                end
            end
            ST_SETTLE: begin
                if (!trackOn) begin
                    state_d = ST_IDLE;
                end else if (tmr.expired) begin
                    state_d = ST_MEASURE;
                end
            end
            ST_MEASURE: begin
                if (!trackOn) begin
                    state_d = ST_IDLE;
                end else begin
                    state_d    = ST_WAIT;
                    tmr.start  = 1'b1;
                    tmr.loadMs = MS_W'(INTERVAL_MS[rateCode]);
                end
            end
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            state_q       <= ST_IDLE;
            converterHold <= 1'b0;
        end else begin
            state_q       <= state_d;
            converterHold <= (state_d == ST_SETTLE) || (state_d == ST_MEASURE);
        end
    end

    // Floor keeps its last value while tracking is off; only srst or regReset clears it
    always_ff @(posedge sys_clk) begin
        if (allReset) begin
            inputVoltageFloor <= '0;
            floorUpdated      <= 1'b0;
        end else begin
            floorUpdated <= (state_q == ST_MEASURE) && trackOn;
            if ((state_q == ST_MEASURE) && trackOn) begin
                inputVoltageFloor <= floorOf(openCircuitVoltage,
                                             fracCode);
            end
        end
    end

    tracking_timer #(
        .TICK (TICK)
    ) u_timer (
        .sys_clk (sys_clk),
        .srst    (srst),
        .tmr     (tmr)
    );

    // --------------------------------------------------------------
    // Checks
    // --------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (srst);

    property p_floor_fraction;
        (state_q == ST_MEASURE) && trackOn && !regReset |=>
            inputVoltageFloor ==
            floorOf($past(openCircuitVoltage), $past(fracCode));
    endproperty
    a_floor_fraction: assert property (p_floor_fraction)
        else $error("floor not set to fraction of measured voltage");

    property p_settle_load;
        tmr.start && (state_d == ST_SETTLE) |->
            tmr.loadMs == MS_W'(SETTLE_MS[dlyCode]);
    endproperty
    a_settle_load: assert property (p_settle_load)
        else $error("settle delay loaded with wrong time");

    property p_interval_load;
        (state_q == ST_MEASURE) && trackOn |->
            tmr.start && (tmr.loadMs == MS_W'(INTERVAL_MS[rateCode]))
            ##1 (state_q == ST_WAIT) && !converterHold;
    endproperty
    a_interval_load: assert property (p_interval_load)
        else $error("interval not started after measurement");

    property p_track_off;
        !trackOn && !$past(trackOn) |-> state_q == ST_IDLE && !converterHold;
    endproperty
    a_track_off: assert property (p_track_off)
        else $error("tracking active while disabled");

    property p_track_wd;
        watchdogExpire && !regReset && !wrTrack |=> $stable(trackReg_q);
    endproperty
    a_track_wd: assert property (p_track_wd)
        else $error("tracking register disturbed by watchdog");

    property p_reg_limit_wd;
        watchdogExpire && !regReset |=> ##1
            thermalRegLimitC == 8'(REG_LIMIT_C[THERMAL_RST[TREG_LO +: 2]]);
    endproperty
    a_reg_limit_wd: assert property (p_reg_limit_wd)
        else $error("regulation limit not restored by watchdog");

    property p_trip_wd;
        watchdogExpire && !regReset |=> ##1
            thermalTripLimitC == 8'(TRIP_LIMIT_C[THERMAL_RST[TRIP_LO +: 2]]);
    endproperty
    a_trip_wd: assert property (p_trip_wd)
        else $error("trip limit not restored by watchdog");

    property p_pulldown_wd;
        watchdogExpire && !regReset |=>
            thermalReg_q[RAIL_BIT:SRC2_BIT] ==
            $past(thermalReg_q[RAIL_BIT:SRC2_BIT]);
    endproperty
    a_pulldown_wd: assert property (p_pulldown_wd)
        else $error("pull-down enables changed by watchdog");

    property p_derate_wd;
        watchdogExpire && !regReset |=> derateReg_q == DERATE_RST ##1
            warmVoltageDropMv ==
            10'(VOLT_DROP_MV[DERATE_RST[WVOLT_LO +: 3]]);
    endproperty
    a_derate_wd: assert property (p_derate_wd)
        else $error("derating not restored by watchdog");

    property p_reserved_zero;
        regRdEn && ((regAddr == THERMAL_ADDR) || (regAddr == DERATE_ADDR))
            |=> regRdData[EN_BIT] == 1'b0;
    endproperty
    a_reserved_zero: assert property (p_reserved_zero)
        else $error("reserved bit read back as one");
endmodule : solar_thermal_config_regs
`default_nettype wire

/* src/solar_thermal_pkg.sv */
// Overview of operation
// - Floor set to selected fraction of measured open-circuit voltage.
// - Wait selected settle delay after switching stops before measuring.
// - Repeat open-circuit measurements at the selected interval.
// - Bit 0 enables tracking; tracking fields ignore watchdog expiry.
// - Thermal regulation limit field, 60 to 120 C, restored to 3h.
// - Thermal trip limit field, 150 to 85 C, restored to 0.
// - Bit 3 connects input rail pull-down; register reset only.
// - Bits 2 and 1 enable source-sense pull-downs; register reset only.
// - Warm band voltage: suspend, drop 800 to 100 mV, or unchanged.
// - Warm band current: suspend, 20 percent, 40 percent, or unchanged.
// - Cool band current uses same coding; derating restored on watchdog.
package solar_thermal_pkg;
    // --------------------------------------------------------------
    // Register map
    // --------------------------------------------------------------
    localparam logic [7:0] TRACK_ADDR     = 8'h15;
    localparam logic [7:0] THERMAL_ADDR   = 8'h16;
    localparam logic [7:0] DERATE_ADDR    = 8'h17;
    localparam logic [7:0] TRACK_RST      = 8'haa;
    localparam logic [7:0] THERMAL_RST    = 8'hc0;
    localparam logic [7:0] DERATE_RST     = 8'h7a;
    localparam logic [7:0] TRACK_WR_MASK  = 8'hff;
    localparam logic [7:0] THERMAL_WR_MASK = 8'hfe;
    localparam logic [7:0] DERATE_WR_MASK = 8'hfe;
    localparam logic [7:0] THERMAL_WD_MASK = 8'hf0;
    localparam logic [7:0] DERATE_WD_MASK = 8'hfe;
    localparam logic [7:0] READ_IDLE      = 8'h00;

    // --------------------------------------------------------------
    // Field positions
    // --------------------------------------------------------------
    localparam int FRAC_LO = 5;
    localparam int DLY_LO  = 3;
    localparam int RATE_LO = 1;
    localparam int EN_BIT  = 0;
    localparam int TREG_LO = 6;
    localparam int TRIP_LO = 4;
    localparam int RAIL_BIT = 3;
    localparam int SRC1_BIT = 2;
    localparam int SRC2_BIT = 1;
    localparam int WVOLT_LO = 5;
    localparam int WCUR_LO  = 3;
    localparam int CCUR_LO  = 1;

    // --------------------------------------------------------------
    // Encodings and timing
    // --------------------------------------------------------------
    localparam int VOLT_W      = 16;
    localparam int MS_W        = 21;
    localparam int PCT_W       = 7;
    localparam int FRAC_SHIFT  = 4;
    localparam logic [4:0] FRAC_BASE = 5'h09;
    localparam logic [1:0] CUR_SUSPEND = 2'h0;
    localparam logic [2:0] VOLT_SUSPEND = 3'h0;
    localparam int CLK_HZ      = 10_000_000;
    localparam int MS_PER_S    = 1000;
    localparam int TICK_CYCLES = CLK_HZ / MS_PER_S;
    localparam int SETTLE_MS [4] = '{50, 300, 2000, 5000};
    localparam int INTERVAL_MS [4] = '{30000, 120000, 600000, 1800000};
    localparam int REG_LIMIT_C [4] = '{60, 80, 100, 120};
    localparam int TRIP_LIMIT_C [4] = '{150, 130, 120, 85};
    localparam int VOLT_DROP_MV [8] = '{0, 800, 600, 400, 300, 200, 100, 0};
    localparam int CUR_PCT [4] = '{0, 20, 40, 100};

    typedef enum logic [1:0] {
        ST_IDLE    = 2'b00,
        ST_WAIT    = 2'b01,
        ST_SETTLE  = 2'b10,
        ST_MEASURE = 2'b11
    } track_state_type;
endpackage : solar_thermal_pkg

/* src/tracking_timer_if.sv */
`timescale 1ns/10ps
`default_nettype none
interface tracking_timer_if
    import solar_thermal_pkg::*;
    ;
    logic            start;
    logic [MS_W-1:0] loadMs;
    logic            expired;

    modport sequencer (output start, output loadMs, input expired);
    modport timer     (input start, input loadMs, output expired);
endinterface : tracking_timer_if
`default_nettype wire

/* src/tracking_timer.sv */
`timescale 1ns/10ps
`default_nettype none
module tracking_timer
    import solar_thermal_pkg::*;
#(
    parameter int TICK = TICK_CYCLES
) (
    input  wire logic         sys_clk,
    input  wire logic         srst,
    tracking_timer_if.timer   tmr
);
    localparam int PW = $clog2(TICK) + 1;
    localparam logic [PW-1:0] TICK_LAST = PW'(TICK - 1);
    localparam logic [MS_W-1:0] MS_ONE = MS_W'(1);

    logic [PW-1:0]   pre_q;
    logic [MS_W-1:0] msLeft_q;
    logic            busy_q;
    logic            expired_q;
    logic            tick;

    // Millisecond prescaler keeps the long intervals in a small counter
    assign tick = busy_q && (pre_q == TICK_LAST);

    always_ff @(posedge sys_clk) begin
        if (srst || tmr.start || !busy_q || tick) begin
            pre_q <= '0;
        end else begin
            pre_q <= pre_q + PW'(1);
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            busy_q    <= 1'b0;
            msLeft_q  <= '0;
            expired_q <= 1'b0;
        end else if (tmr.start) begin
            busy_q    <= 1'b1;
            msLeft_q  <= tmr.loadMs;
            expired_q <= 1'b0;
        end else begin
            expired_q <= tick && (msLeft_q == MS_ONE);
            if (tick) begin
                msLeft_q <= msLeft_q - MS_ONE;
                busy_q   <= (msLeft_q != MS_ONE);
            end
        end
    end

    assign tmr.expired = expired_q;
endmodule : tracking_timer
`default_nettype wire

/* verif/solar_thermal_config_regs_tb.sv */
`timescale 1ns/10ps
`default_nettype none
module solar_thermal_config_regs_tb
    import solar_thermal_pkg::*;
;
    // ----------------------------------------------------------------
    // Setup
    // ----------------------------------------------------------------
    // Short tick keeps the 30 s interval near 60000 cycles
    localparam int TICKS = 2;
    localparam int LIMIT = 100000;
    logic              sys_clk;
    logic              srst;
    logic [7:0]        regAddr;
    logic [7:0]        regWrData;
    logic              regWrEn;
    logic              regRdEn;
    logic [7:0]        regRdData;
    logic              regReset;
    logic              watchdogExpire;
    logic [VOLT_W-1:0] openCircuitVoltage;
    logic              converterHold;
    logic [VOLT_W-1:0] inputVoltageFloor;
    logic              floorUpdated;
    logic [7:0]        thermalRegLimitC;
    logic [7:0]        thermalTripLimitC;
    logic              inputRailPulldownOn;
    logic              firstSourcePulldownOn;
    logic              secondSourcePulldownOn;
    logic              warmChargeSuspend;
    logic [9:0]        warmVoltageDropMv;
    logic [PCT_W-1:0]  warmCurrentPct;
    logic              coolChargeSuspend;
    logic [PCT_W-1:0]  coolCurrentPct;
    int                failures;
    int                cmp_count;
    int                cycles;
    logic [7:0]        tExp;
    logic [7:0]        dExp;

    solar_thermal_config_regs #(.TICK(TICKS)) dut_u (
        .sys_clk(sys_clk), .srst(srst), .regAddr(regAddr),
        .regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn),
        .regRdData(regRdData), .regReset(regReset),
        .watchdogExpire(watchdogExpire),
        .openCircuitVoltage(openCircuitVoltage),
        .converterHold(converterHold),
        .inputVoltageFloor(inputVoltageFloor),
        .floorUpdated(floorUpdated),
        .thermalRegLimitC(thermalRegLimitC),
        .thermalTripLimitC(thermalTripLimitC),
        .inputRailPulldownOn(inputRailPulldownOn),
        .firstSourcePulldownOn(firstSourcePulldownOn),
        .secondSourcePulldownOn(secondSourcePulldownOn),
        .warmChargeSuspend(warmChargeSuspend),
        .warmVoltageDropMv(warmVoltageDropMv),
        .warmCurrentPct(warmCurrentPct),
        .coolChargeSuspend(coolChargeSuspend),
        .coolCurrentPct(coolCurrentPct));

    initial begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end

    // ----------------------------------------------------------------
    // Expected values and checks
    // ----------------------------------------------------------------
    function automatic logic [31:0] tripC(input logic [1:0] c);
        case (c)
            2'h0: return 32'd150;
            2'h1: return 32'd130;
            2'h2: return 32'd120;
            default: return 32'd85;
        endcase
    endfunction : tripC

    function automatic logic [31:0] dropMv(input logic [2:0] c);
        if (c == 3'h0 || c == 3'h7) return 32'd0;
        if (c < 3'h4) return 32'd1000 - 32'd200 * 32'(c);
        return 32'd700 - 32'd100 * 32'(c);
    endfunction : dropMv

    function automatic logic [31:0] pct(input logic [1:0] c);
        case (c)
            2'h0: return 32'd0;
            2'h1: return 32'd20;
            2'h2: return 32'd40;
            default: return 32'd100;
        endcase
    endfunction : pct

    function automatic int settleMs(input logic [1:0] c);
        case (c)
            2'h0: return 50;
            2'h1: return 300;
            2'h2: return 2000;
            default: return 5000;
        endcase
    endfunction : settleMs

    function automatic logic [31:0] floorOf(input logic [15:0] v,
                                            input logic [2:0] c);
        logic [20:0] p;
        p = 21'(v) * (21'd9 + 21'(c));
        return 32'(p[19:4]);
    endfunction : floorOf

    task automatic checkVal(input string what, input logic [31:0] exp,
                            input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            failures++;
            $display("wrong value %s expected %0h seen %0h", what, exp, got);
        end
    endtask : checkVal

    task automatic checkReg(input string what, input logic [7:0] exp,
                            input logic [7:0] got);
        cmp_count++;
        if (got !== exp) begin
            failures++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask : checkReg

    task automatic checkDecode(input logic [7:0] t, input logic [7:0] d);
        checkVal("regLimit", 32'd60 + 32'd20 * 32'(t[7:6]),
                 32'(thermalRegLimitC));
        checkVal("tripLimit", tripC(t[5:4]),
                 32'(thermalTripLimitC));
        checkVal("railPd", 32'(t[3]), 32'(inputRailPulldownOn));
        checkVal("src1Pd", 32'(t[2]), 32'(firstSourcePulldownOn));
        checkVal("src2Pd", 32'(t[1]), 32'(secondSourcePulldownOn));
        checkVal("warmSusp", 32'(d[7:5] == 3'h0 || d[4:3] == 2'h0),
                 32'(warmChargeSuspend));
        checkVal("warmDrop", dropMv(d[7:5]),
                 32'(warmVoltageDropMv));
        checkVal("warmPct", pct(d[4:3]), 32'(warmCurrentPct));
        checkVal("coolPct", pct(d[2:1]), 32'(coolCurrentPct));
        checkVal("coolSusp", 32'(d[2:1] == 2'h0),
                 32'(coolChargeSuspend));
    endtask : checkDecode

    // ----------------------------------------------------------------
    // Bus and pulse drivers
    // ----------------------------------------------------------------
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        regAddr <= a;
        regWrData <= d;
        regWrEn <= 1'b1;
        @(posedge sys_clk);
        regWrEn <= 1'b0;
    endtask : wr

    // Waits an extra edge; read data holds until the next read
    task automatic rdChk(input logic [7:0] a, input logic [7:0] exp);
        @(posedge sys_clk);
        regAddr <= a;
        regRdEn <= 1'b1;
        @(posedge sys_clk);
        regRdEn <= 1'b0;
        @(posedge sys_clk);
        #1;
        checkReg("regRdData", exp, regRdData);
    endtask : rdChk

    task automatic settle2;
        repeat (2) @(posedge sys_clk);
        #1;
    endtask : settle2

    task automatic endTest(input string name);
        $display("test %s finished, mismatches so far %0d", name, failures);
    endtask : endTest

    // One measurement; leaves tracking enabled
    task automatic measure(input logic [2:0] f, input logic [1:0] dl);
        logic [15:0] v;
        int          n;
        int          s;
        v = 16'($urandom);
        @(posedge sys_clk);
        openCircuitVoltage <= v;
        wr(TRACK_ADDR, {f, dl, 2'h0, 1'b1});
        n = 0;
        s = settleMs(dl) * TICKS;
        while (floorUpdated !== 1'b1 && n < 20000) begin
            @(posedge sys_clk);
            #1;
            n++;
            if (n == 3) begin
                checkVal("holdOn", 32'h1, 32'(converterHold));
            end
        end
        checkVal("settleTime", 32'h1, 32'(n >= s && n <= s + 6));
        checkVal("floor", floorOf(v, f), 32'(inputVoltageFloor));
        checkVal("holdDone", 32'h0, 32'(converterHold));
        checkVal("updPulse", 32'h1, 32'(floorUpdated));
        @(posedge sys_clk);
        #1;
        checkVal("updOnce", 32'h0, 32'(floorUpdated));
    endtask : measure

    task automatic results;
        $display("comparisons %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : results

    // Cut a hang short; tests need about 76000 cycles
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == LIMIT) begin
            failures++;
            $display("wrong value runTime expected finish seen timeout");
            results();
        end
    end

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        logic [7:0] a;
        logic [7:0] d;
        int         n;
        srst = 1'b1;
        regAddr = 8'h00;
        regWrData = 8'h00;
        regWrEn = 1'b0;
        regRdEn = 1'b0;
        regReset = 1'b0;
        watchdogExpire = 1'b0;
        openCircuitVoltage = 16'h0000;
        failures = 0;
        cmp_count = 0;
        cycles = 0;
        void'($urandom(32'h5d632536));
        repeat (10) @(posedge sys_clk);
        srst <= 1'b0;
        rdChk(TRACK_ADDR, 8'haa);
        rdChk(THERMAL_ADDR, 8'hc0);
        rdChk(DERATE_ADDR, 8'h7a);
        rdChk(8'h18, 8'h00);
        checkDecode(8'hc0, 8'h7a);
        endTest("reset");
        tExp = 8'hc0;
        dExp = 8'h7a;
        for (int k = 0; k < 24; k++) begin
            a = TRACK_ADDR + 8'(k % 3);
            d = (k < 3) ? 8'hff : (k < 6) ? 8'h00 : 8'($urandom);
            if (a == TRACK_ADDR) d[0] = 1'b0;
            wr(a, d);
            if (a == THERMAL_ADDR) tExp = d & 8'hfe;
            if (a == DERATE_ADDR) dExp = d & 8'hfe;
            rdChk(a, (a == TRACK_ADDR) ? d : d & 8'hfe);
            checkDecode(tExp, dExp);
        end
        endTest("readWrite");
        wr(TRACK_ADDR, 8'hfe);
        wr(THERMAL_ADDR, 8'hff);
        wr(DERATE_ADDR, 8'hff);
        @(posedge sys_clk);
        watchdogExpire <= 1'b1;
        regAddr <= THERMAL_ADDR;
        regWrData <= 8'h3f;
        regWrEn <= 1'b1;
        @(posedge sys_clk);
        watchdogExpire <= 1'b0;
        regWrEn <= 1'b0;
        rdChk(TRACK_ADDR, 8'hfe);
        rdChk(THERMAL_ADDR, 8'hce);
        rdChk(DERATE_ADDR, 8'h7a);
        checkDecode(8'hce, 8'h7a);
        endTest("watchdog");
        for (int i = 0; i < 12; i++) begin
            measure((i < 8) ? 3'(i) : 3'($urandom),
                    (i < 8) ? 2'h0 : 2'(i - 8));
            wr(TRACK_ADDR, 8'h00);
            @(posedge sys_clk);
            #1;
            checkVal("holdOff", 32'h0, 32'(converterHold));
        end
        endTest("tracking");
        wr(TRACK_ADDR, 8'hb9);
        repeat (20) @(posedge sys_clk);
        #1;
        checkVal("holdAbortPre", 32'h1, 32'(converterHold));
        wr(TRACK_ADDR, 8'h00);
        @(posedge sys_clk);
        #1;
        checkVal("holdAbort", 32'h0, 32'(converterHold));
        endTest("abort");
        measure(3'($urandom), 2'h0);
        n = 0;
        while (converterHold !== 1'b1 && n < 70000) begin
            @(posedge sys_clk);
            #1;
            n++;
        end
        checkVal("interval", 32'h1,
                 32'(n >= 30000 * TICKS && n <= 30000 * TICKS + 6));
        endTest("interval");
        @(posedge sys_clk);
        regReset <= 1'b1;
        @(posedge sys_clk);
        regReset <= 1'b0;
        settle2();
        checkVal("floorClear", 32'h0, 32'(inputVoltageFloor));
        checkVal("holdReset", 32'h0, 32'(converterHold));
        rdChk(TRACK_ADDR, 8'haa);
        rdChk(THERMAL_ADDR, 8'hc0);
        rdChk(DERATE_ADDR, 8'h7a);
        checkDecode(8'hc0, 8'h7a);
        endTest("regReset");
        results();
    end
endmodule : solar_thermal_config_regs_tb
`default_nettype wire
